/* File: src/axm_pkg.sv */
// constants and types shared by the exclusive monitor and ordering front end
// ============================================================
`default_nettype none

package axm_pkg;

  // ==========================================================
  // response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;

  // ==========================================================
  // sizes and reset values
  localparam int         CNT_W       = 4;      // outstanding counter width per master
  localparam int         DEF_NUM_MON = 2;      // default monitor count
  localparam int         DEF_NUM_IF  = 2;      // default memory interfaces
  localparam logic       RDY_RST     = 1'b1;   // response stage ready after reset

  typedef logic [1:0] axm_resp_t;

  // grant source of the address arbiter
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_MGR,
    SRC_RD,
    SRC_WR
  } axm_src_t;

endpackage : axm_pkg

`default_nettype wire

/* File: src/axm_resp_stage.sv */
// one-deep registered response stage between memory side and bus side
`default_nettype none

module axm_resp_stage #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,    // 20 MHz clock
  input  wire logic         reset,      // async, active high
  input  wire logic         in_valid,   // memory side offers a response
  input  wire logic [W-1:0] in_data,    // packed response
  output logic              in_ready,   // stage empty
  output logic              out_valid,  // bus side response valid
  output logic [W-1:0]      out_data,   // registered response
  input  wire logic         out_ready   // bus side accepts
);
  import axm_pkg::*;

  // ==========================================================
  // half-rate hand-off keeps every output a plain flop
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      in_ready  <= RDY_RST;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (in_valid && in_ready) begin
      in_ready  <= 1'b0;
      out_valid <= 1'b1;
      out_data  <= in_data;
    end else if (out_valid && out_ready) begin
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
  end

  // ==========================================================
  chk_hold_stable: assert property (@(posedge ref_clk) disable iff (reset)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("response changed while stalled");

  chk_take_once: assert property (@(posedge ref_clk) disable iff (reset)
    in_valid && in_ready |=> out_valid && !in_ready && out_data == $past(in_data))
    else $error("response not captured");

endmodule : axm_resp_stage

`default_nettype wire

/* File: src/axm_front.sv */
// address arbiter, ordering guard and exclusive monitors of the bus front end
`default_nettype none

module axm_front #(
  parameter int AW          = 32,
  parameter int ID_W        = 2,
  parameter int DW          = 32,
  parameter int NUM_MON     = axm_pkg::DEF_NUM_MON,
  parameter int NUM_IF      = axm_pkg::DEF_NUM_IF,
  parameter int IF_SEL_BIT  = 24
) (
  input  wire logic              ref_clk,      // 20 MHz clock
  input  wire logic              reset,        // async, active high
  // read address
  input  wire logic              ar_valid,     // read request
  input  wire logic [AW-1:0]     ar_addr,      // start byte address
  input  wire logic [ID_W-1:0]   ar_id,        // master id
  input  wire logic [7:0]        ar_len,       // beats minus one
  input  wire logic [2:0]        ar_size,      // log2 bytes per beat
  input  wire logic              ar_lock,      // exclusive read
  output logic                   ar_ready,     // one-cycle accept
  // write address
  input  wire logic              aw_valid,     // write request
  input  wire logic [AW-1:0]     aw_addr,      // start byte address
  input  wire logic [ID_W-1:0]   aw_id,        // master id
  input  wire logic [7:0]        aw_len,       // beats minus one
  input  wire logic [2:0]        aw_size,      // log2 bytes per beat
  input  wire logic              aw_lock,      // exclusive write
  output logic                   aw_ready,     // one-cycle accept
  // write data
  input  wire logic              w_valid,      // beat offered
  input  wire logic [DW/8-1:0]   w_strb,       // byte strobes
  input  wire logic              w_last,       // last beat
  output logic                   w_ready,      // beat accept
  // internal manager
  input  wire logic              mgr_valid,    // manager request
  input  wire logic [AW-1:0]     mgr_addr,     // manager address
  output logic                   mgr_ready,    // one-cycle accept
  // command to memory interfaces
  output logic                   cmd_valid,    // command pending
  output logic                   cmd_write,    // write command
  output logic                   cmd_mgr,      // from manager
  output logic [AW-1:0]          cmd_addr,     // byte address
  output logic [ID_W-1:0]        cmd_id,       // master id
  output logic [7:0]             cmd_len,      // beats minus one
  output logic [2:0]             cmd_size,     // beat size
  output logic                   cmd_if,       // target interface
  output logic                   cmd_exok,     // exclusive tag, echoed back
  input  wire logic              cmd_ready,    // command taken
  output logic                   mem_w_valid,  // beat to memory
  output logic [DW/8-1:0]        mem_w_strb,   // strobes to memory
  output logic                   mem_w_last,   // last beat to memory
  input  wire logic              mem_w_ready,  // memory takes beat
  // responses from memory
  input  wire logic              mem_b_valid,  // write done
  input  wire logic [ID_W-1:0]   mem_b_id,     // its master
  input  wire logic              mem_b_exok,   // echoed tag
  output logic                   mem_b_ready,  // stage free
  input  wire logic              mem_r_valid,  // read beat
  input  wire logic [ID_W-1:0]   mem_r_id,     // its master
  input  wire logic [DW-1:0]     mem_r_data,   // read data
  input  wire logic              mem_r_last,   // last beat
  input  wire logic              mem_r_exok,   // echoed tag
  output logic                   mem_r_ready,  // stage free
  // bus responses
  output logic                   b_valid,      // write response
  output logic [ID_W-1:0]        b_id,         // its master
  output axm_pkg::axm_resp_t     b_resp,       // OKAY or EXOKAY
  input  wire logic              b_ready,      // master accepts
  output logic                   r_valid,      // read beat
  output logic [ID_W-1:0]        r_id,         // its master
  output logic [DW-1:0]          r_data,       // read data
  output logic                   r_last,       // last beat
  output axm_pkg::axm_resp_t     r_resp,       // OKAY or EXOKAY
  input  wire logic              r_ready       // master accepts
);
  import axm_pkg::*;

  localparam int NUM_ID = 1 << ID_W;

  // ==========================================================
  // elaboration checks
  if (NUM_IF < 1 || NUM_IF > 2) begin : g_bad_if
    $error("NUM_IF must be 1 or 2");
  end
  if (NUM_MON < 1 || AW < 12 || IF_SEL_BIT >= AW || DW < 8) begin : g_bad_cfg
    $error("unsupported monitor count or widths");
  end

  // ==========================================================
  // incrementing-burst compare mask
  function automatic logic [AW-1:0] cmp_mask(input logic [AW-1:0] addr,
                                             input logic [7:0]    len,
                                             input logic [2:0]    size);
    logic [AW-1:0] bytes;
    logic [AW-1:0] fill;
    bytes = (AW'(len) + AW'(1)) << size;
    fill  = addr ^ (addr + bytes - AW'(1));
    for (int i = AW - 2; i >= 0; i--) begin
      fill[i] = fill[i] | fill[i+1];
    end
    return ~fill;
  endfunction : cmp_mask

  // ==========================================================
  // state
  logic                  rr_last_reg;     // 1: last read or write grant was a write
  logic                  wr_open_reg;     // write data burst in progress
  logic                  wr_fail_reg;     // that burst is a failed exclusive
  logic [CNT_W-1:0]      rd_cnt_reg [NUM_ID];
  logic [CNT_W-1:0]      wr_cnt_reg [NUM_ID];
  logic                  rd_if_reg  [NUM_ID];
  logic                  wr_if_reg  [NUM_ID];
  logic                  mon_valid_reg [NUM_MON];
  logic [AW-1:0]         mon_addr_reg  [NUM_MON];
  logic [ID_W-1:0]       mon_id_reg    [NUM_MON];

  logic                  ar_sel;
  logic                  aw_sel;
  logic                  rd_ok;
  logic                  wr_ok;
  logic                  rd_req;
  logic                  wr_req;
  logic                  arb_free;
  axm_src_t              src_next;
  logic                  grant_rd;
  logic                  grant_wr;
  logic [AW-1:0]         wr_mask;
  logic                  ex_hit;
  logic                  ld_ok;
  logic [$clog2(NUM_MON+1)-1:0] ld_idx;
  logic                  b_fire;
  logic                  r_fire;

  assign ar_sel  = (NUM_IF == 2) ? ar_addr[IF_SEL_BIT] : 1'b0;
  assign aw_sel  = (NUM_IF == 2) ? aw_addr[IF_SEL_BIT] : 1'b0;
  assign wr_mask = cmp_mask(aw_addr, aw_len, aw_size);
  assign b_fire  = b_valid && b_ready;
  assign r_fire  = r_valid && r_ready && r_last;

  // ordering guard: a master may not open a second interface while busy on one
  always_comb begin
    rd_ok = (NUM_IF == 1) || (rd_cnt_reg[ar_id] == '0)
            || (rd_if_reg[ar_id] == ar_sel);
    rd_ok = rd_ok && (rd_cnt_reg[ar_id] != '1);
    wr_ok = (NUM_IF == 1) || (wr_cnt_reg[aw_id] == '0)
            || (wr_if_reg[aw_id] == aw_sel);
    wr_ok = wr_ok && (wr_cnt_reg[aw_id] != '1);
  end

  // ==========================================================
  // arbiter: manager first, then read and write take turns
  assign arb_free = !ar_ready && !aw_ready && !mgr_ready && (!cmd_valid || cmd_ready);
  assign rd_req   = ar_valid && rd_ok;
  assign wr_req   = aw_valid && wr_ok && !wr_open_reg;

  always_comb begin
    src_next = SRC_NONE;
    if (arb_free) begin
      if (mgr_valid) begin
        src_next = SRC_MGR;
      end else if (rd_req && wr_req) begin
        src_next = rr_last_reg ? SRC_RD : SRC_WR;
      end else if (rd_req) begin
        src_next = SRC_RD;
      end else if (wr_req) begin
        src_next = SRC_WR;
      end
    end
  end

  assign grant_rd = (src_next == SRC_RD);
  assign grant_wr = (src_next == SRC_WR);

  // ==========================================================
  // monitor lookup: reuse the master's own monitor, else first free one
  always_comb begin
    ex_hit = 1'b0;
    ld_ok  = 1'b0;
    ld_idx = '0;
    for (int m = 0; m < NUM_MON; m++) begin
      if (mon_valid_reg[m] && mon_id_reg[m] == aw_id && mon_addr_reg[m] == aw_addr) begin
        ex_hit = 1'b1;
      end
    end
    for (int m = NUM_MON - 1; m >= 0; m--) begin
      if (!mon_valid_reg[m]) begin
        ld_ok  = 1'b1;
        ld_idx = ($clog2(NUM_MON+1))'(m);
      end
    end
    for (int m = 0; m < NUM_MON; m++) begin
      if (mon_valid_reg[m] && mon_id_reg[m] == ar_id) begin
        ld_ok  = 1'b1;
        ld_idx = ($clog2(NUM_MON+1))'(m);
      end
    end
  end

  // ==========================================================
  // exclusive monitors, each holding one access
  for (genvar m = 0; m < NUM_MON; m++) begin : g_mon
    logic other_hit;
    assign other_hit = mon_valid_reg[m] && mon_id_reg[m] != aw_id
                       && ((mon_addr_reg[m] & wr_mask) == (aw_addr & wr_mask));

    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        mon_valid_reg[m] <= 1'b0;
        mon_addr_reg[m]  <= '0;
        mon_id_reg[m]    <= '0;
      end else if (grant_rd && ar_lock && ld_ok && ld_idx == m) begin
        mon_valid_reg[m] <= 1'b1;
        mon_addr_reg[m]  <= ar_addr;
        mon_id_reg[m]    <= ar_id;
      end else if (grant_wr && other_hit) begin
        mon_valid_reg[m] <= 1'b0;
      end else if (grant_wr && aw_lock && mon_id_reg[m] == aw_id) begin
        mon_valid_reg[m] <= 1'b0;
      end
    end

    chk_mon_clear: assert property (@(posedge ref_clk) disable iff (reset)
      grant_wr && other_hit |=> !mon_valid_reg[m])
      else $error("conflicting write left monitor armed");
  end

  // ==========================================================
  // grant pulses and command register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ar_ready    <= 1'b0;
      aw_ready    <= 1'b0;
      mgr_ready   <= 1'b0;
      rr_last_reg <= 1'b0;
      cmd_valid   <= 1'b0;
      cmd_write   <= 1'b0;
      cmd_mgr     <= 1'b0;
      cmd_addr    <= '0;
      cmd_id      <= '0;
      cmd_len     <= '0;
      cmd_size    <= '0;
      cmd_if      <= 1'b0;
      cmd_exok    <= 1'b0;
    end else begin
      ar_ready  <= grant_rd;
      aw_ready  <= grant_wr;
      mgr_ready <= (src_next == SRC_MGR);
      case (src_next)
        SRC_MGR: begin
          cmd_valid <= 1'b1;
          cmd_write <= 1'b0;
          cmd_mgr   <= 1'b1;
          cmd_addr  <= mgr_addr;
          cmd_id    <= '0;
          cmd_len   <= '0;
          cmd_size  <= '0;
          cmd_if    <= (NUM_IF == 2) ? mgr_addr[IF_SEL_BIT] : 1'b0;
          cmd_exok  <= 1'b0;
        end
        SRC_RD: begin
          rr_last_reg <= 1'b0;
          cmd_valid   <= 1'b1;
          cmd_write   <= 1'b0;
          cmd_mgr     <= 1'b0;
          cmd_addr    <= ar_addr;
          cmd_id      <= ar_id;
          cmd_len     <= ar_len;
          cmd_size    <= ar_size;
          cmd_if      <= ar_sel;
          cmd_exok    <= ar_lock && ld_ok;
        end
        SRC_WR: begin
          rr_last_reg <= 1'b1;
          cmd_valid   <= 1'b1;
          cmd_write   <= 1'b1;
          cmd_mgr     <= 1'b0;
          cmd_addr    <= aw_addr;
          cmd_id      <= aw_id;
          cmd_len     <= aw_len;
          cmd_size    <= aw_size;
          cmd_if      <= aw_sel;
          cmd_exok    <= aw_lock && ex_hit;
        end
        SRC_NONE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_valid <= 1'b0;
          end
        end
        default: begin
          cmd_valid <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // outstanding count and interface per master, both directions
  for (genvar i = 0; i < NUM_ID; i++) begin : g_ord
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        rd_cnt_reg[i] <= '0;
        rd_if_reg[i]  <= 1'b0;
      end else begin
        if (grant_rd && ar_id == i) begin
          rd_if_reg[i] <= ar_sel;
        end
        rd_cnt_reg[i] <= rd_cnt_reg[i] + CNT_W'(grant_rd && ar_id == i)
                         - CNT_W'(r_fire && r_id == i);
      end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        wr_cnt_reg[i] <= '0;
        wr_if_reg[i]  <= 1'b0;
      end else begin
        if (grant_wr && aw_id == i) begin
          wr_if_reg[i] <= aw_sel;
        end
        wr_cnt_reg[i] <= wr_cnt_reg[i] + CNT_W'(grant_wr && aw_id == i)
                         - CNT_W'(b_fire && b_id == i);
      end
    end
  end

  // ==========================================================
  // write data path: one burst at a time, strobes killed on a failed exclusive
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_open_reg <= 1'b0;
      wr_fail_reg <= 1'b0;
      w_ready     <= 1'b0;
      mem_w_valid <= 1'b0;
      mem_w_strb  <= '0;
      mem_w_last  <= 1'b0;
    end else begin
      if (grant_wr) begin
        wr_open_reg <= 1'b1;
        wr_fail_reg <= aw_lock && !ex_hit;
        w_ready     <= 1'b1;
      end else if (w_valid && w_ready) begin
        w_ready     <= 1'b0;
        mem_w_valid <= 1'b1;
        mem_w_strb  <= wr_fail_reg ? '0 : w_strb;
        mem_w_last  <= w_last;
      end else if (mem_w_valid && mem_w_ready) begin
        mem_w_valid <= 1'b0;
        w_ready     <= !mem_w_last;
        wr_open_reg <= !mem_w_last;
      end
    end
  end

  // ==========================================================
  // response stages; the echoed tag picks the response code
  axm_resp_stage #(.W(ID_W + 2)) u_b_stage (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (mem_b_valid),
    .in_data   ({mem_b_id, mem_b_exok ? RESP_EXOKAY : RESP_OKAY}),
    .in_ready  (mem_b_ready),
    .out_valid (b_valid),
    .out_data  ({b_id, b_resp}),
    .out_ready (b_ready)
  );

  axm_resp_stage #(.W(ID_W + DW + 3)) u_r_stage (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (mem_r_valid),
    .in_data   ({mem_r_id, mem_r_data, mem_r_last,
                 mem_r_exok ? RESP_EXOKAY : RESP_OKAY}),
    .in_ready  (mem_r_ready),
    .out_valid (r_valid),
    .out_data  ({r_id, r_data, r_last, r_resp}),
    .out_ready (r_ready)
  );

  // ==========================================================
  // checks
  chk_fail_strobe_low: assert property (@(posedge ref_clk) disable iff (reset)
    mem_w_valid && wr_fail_reg |-> mem_w_strb == '0)
    else $error("failed exclusive wrote data");

  chk_mgr_first: assert property (@(posedge ref_clk) disable iff (reset)
    arb_free && mgr_valid |=> mgr_ready && !ar_ready && !aw_ready)
    else $error("manager not served first");

  chk_rr_turn: assert property (@(posedge ref_clk) disable iff (reset)
    arb_free && !mgr_valid && rd_req && wr_req && !rr_last_reg |=> aw_ready && !ar_ready)
    else $error("round robin turn skipped");

  chk_rd_order: assert property (@(posedge ref_clk) disable iff (reset)
    ar_valid && NUM_IF == 2 && rd_cnt_reg[ar_id] != '0 && rd_if_reg[ar_id] != ar_sel
    |=> !ar_ready)
    else $error("read opened second interface");

  chk_wr_order: assert property (@(posedge ref_clk) disable iff (reset)
    aw_valid && NUM_IF == 2 && wr_cnt_reg[aw_id] != '0 && wr_if_reg[aw_id] != aw_sel
    |=> !aw_ready)
    else $error("write opened second interface");

  chk_excl_tag: assert property (@(posedge ref_clk) disable iff (reset)
    grant_wr && aw_lock && !ex_hit |=> cmd_valid && cmd_write && !cmd_exok)
    else $error("unmonitored exclusive tagged ok");

  chk_mask_span: assert property (@(posedge ref_clk) disable iff (reset)
    grant_wr |-> ((aw_addr ^ (aw_addr + ((AW'(aw_len) + AW'(1)) << aw_size) - AW'(1)))
                  & wr_mask) == '0 && wr_mask[AW-1])
    else $error("mask does not cover written bytes");

  chk_resp_code: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(b_valid) |-> b_resp == ($past(mem_b_exok) ? RESP_EXOKAY : RESP_OKAY))
    else $error("write response code wrong");

endmodule : axm_front

`default_nettype wire

/* File: tb/axm_mem_model.sv */
// memory side model: takes commands, absorbs beats, echoes the tag on responses
`default_nettype none
// ==========
// memory model
module axm_mem_model (
  input  wire logic        ref_clk,     // bus clock
  input  wire logic        cmd_valid,   // command offered
  input  wire logic        cmd_write,   // write command
  input  wire logic [1:0]  cmd_id,      // master id
  input  wire logic [7:0]  cmd_len,     // beats minus one
  input  wire logic        cmd_exok,    // tag to echo
  input  wire logic        cmd_mgr,     // manager command, dropped unanswered
  output logic             cmd_ready,   // always free
  input  wire logic        mem_w_valid, // beat offered
  input  wire logic        mem_w_last,  // last beat
  output logic             mem_w_ready, // always free
  output logic             mem_b_valid, // write done
  output logic [1:0]       mem_b_id,    // its master
  output logic             mem_b_exok,  // echoed tag
  input  wire logic        mem_b_ready, // stage free
  output logic             mem_r_valid, // read beat
  output logic [1:0]       mem_r_id,    // its master
  output logic [31:0]      mem_r_data,  // read data
  output logic             mem_r_last,  // last beat
  output logic             mem_r_exok,  // echoed tag
  input  wire logic        mem_r_ready  // stage free
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] q[$];
  logic [11:0] c;
  int lasts = 0;
  int used = 0;
  int i;
  assign cmd_ready = 1'b1;
  assign mem_w_ready = 1'b1;
  // commands in issue order, so one master never sees overtaking
  always @(posedge ref_clk)
    if (cmd_valid && !cmd_mgr) q.push_back({cmd_write, cmd_id, cmd_len, cmd_exok});
  always @(posedge ref_clk) if (mem_w_valid && mem_w_last) lasts <= lasts + 1;
  // serve one command at a time; released lines flip so stale data shows
  initial begin
    {mem_b_valid, mem_b_id, mem_b_exok, mem_r_valid, mem_r_id, mem_r_last, mem_r_exok} = '0;
    mem_r_data = 32'hFFFF_FFFF;
    forever begin
      @(posedge ref_clk);
      if (q.size() != 0) begin
        c = q.pop_front();
        if (c[11]) begin
          while (lasts == used) @(posedge ref_clk);
          used++;
          #1 {mem_b_valid, mem_b_id, mem_b_exok} = {1'b1, c[10:9], c[0]};
          do @(posedge ref_clk); while (!mem_b_ready);
          #1 mem_b_valid = 1'b0;
          mem_b_id = ~mem_b_id;
        end else begin
          for (i = 0; i <= int'(c[8:1]); i++) begin
            #1 {mem_r_valid, mem_r_id, mem_r_last, mem_r_exok} = {1'b1, c[10:9], i == c[8:1], c[0]};
            mem_r_data = 32'hA500_0000 + 32'(i);
            do @(posedge ref_clk); while (!mem_r_ready);
          end
          #1 mem_r_valid = 1'b0;
          mem_r_data = ~mem_r_data;
          mem_r_id = ~mem_r_id;
        end
      end
    end
  end
endmodule : axm_mem_model
`default_nettype wire

/* File: tb/axm_front_test.sv */
// self-checking bench for the exclusive monitor front end
`default_nettype none
// ==========
// bench top
module axm_front_test;
  timeunit 1ns;
  timeprecision 1ns;
  import axm_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ar_valid, ar_lock, ar_ready, aw_valid, aw_lock, aw_ready, w_valid, w_last, w_ready;
  logic mgr_valid, mgr_ready, cmd_valid, cmd_write, cmd_mgr, cmd_if, cmd_exok, cmd_ready;
  logic mem_w_valid, mem_w_last, mem_w_ready, mem_b_valid, mem_b_exok, mem_b_ready;
  logic mem_r_valid, mem_r_last, mem_r_exok, mem_r_ready, b_valid, b_ready;
  logic r_valid, r_last, r_ready;
  logic [31:0] ar_addr, aw_addr, mgr_addr, cmd_addr, mem_r_data, r_data;
  logic [1:0]  ar_id, aw_id, cmd_id, mem_b_id, mem_r_id, b_id, r_id, got_id;
  logic [7:0]  ar_len, aw_len, cmd_len;
  logic [2:0]  ar_size, aw_size, cmd_size;
  logic [3:0]  w_strb, mem_w_strb, seen_strb;
  axm_resp_t   b_resp, r_resp, got;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          k;
  axm_front DUT (.*);
  axm_mem_model MEM (.*);
  always #25 ref_clk = ~ref_clk;
  // last strobes that reached memory
  always @(posedge ref_clk) if (mem_w_valid && mem_w_ready) seen_strb <= mem_w_strb;
  task automatic chk_resp(input string what, input axm_resp_t e, input axm_resp_t s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, e, s);
    end
  endtask : chk_resp
  task automatic chk_strb(input string what, input logic [3:0] e, input logic [3:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, e, s);
    end
  endtask : chk_strb
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, e, s);
    end
  endtask : chk_word
  // single-beat read; waits for data before the next access
  task automatic rd(input logic [1:0] id, input logic [31:0] a, input logic lk);
    @(negedge ref_clk);
    {ar_valid, ar_id, ar_addr, ar_len, ar_size, ar_lock} = {1'b1, id, a, 8'h00, 3'h2, lk};
    k = 0;
    do @(posedge ref_clk); while (!ar_ready && ++k < 50);
    if (k == 50) n_mismatch++;
    @(negedge ref_clk);
    ar_valid = 1'b0;
    k = 0;
    do @(posedge ref_clk); while (!(r_valid && r_last) && ++k < 50);
    if (k == 50) n_mismatch++;
    got = r_resp;
  endtask : rd
  task automatic wr(input logic [1:0] id, input logic [31:0] a, input logic [7:0] n, input logic lk);
    @(negedge ref_clk);
    {aw_valid, aw_id, aw_addr, aw_len, aw_size, aw_lock} = {1'b1, id, a, n, 3'h2, lk};
    k = 0;
    do @(posedge ref_clk); while (!aw_ready && ++k < 50);
    if (k == 50) n_mismatch++;
    @(negedge ref_clk);
    aw_valid = 1'b0;
    for (int i = 0; i <= int'(n); i++) begin
      {w_valid, w_strb, w_last} = {1'b1, 4'hF, i == int'(n)};
      k = 0;
      do @(posedge ref_clk); while (!w_ready && ++k < 50);
      if (k == 50) n_mismatch++;
      @(negedge ref_clk);
    end
    w_valid = 1'b0;
    k = 0;
    do @(posedge ref_clk); while (!b_valid && ++k < 50);
    if (k == 50) n_mismatch++;
    got = b_resp;
    got_id = b_id;
  endtask : wr
  task automatic t_two_mon();
    rd(2'h0, 32'h100, 1'b1);
    chk_resp("excl read 0", RESP_EXOKAY, got);
    rd(2'h1, 32'h200, 1'b1);
    chk_resp("excl read 1", RESP_EXOKAY, got);
    rd(2'h2, 32'h300, 1'b1);
    chk_resp("excl read no monitor", RESP_OKAY, got);
    wr(2'h0, 32'h100, 8'h00, 1'b1);
    chk_resp("excl write 0", RESP_EXOKAY, got);
    wr(2'h1, 32'h200, 8'h00, 1'b1);
    chk_resp("excl write 1", RESP_EXOKAY, got);
    chk_word("write id", 32'h1, 32'(got_id));
    wr(2'h2, 32'h300, 8'h00, 1'b1);
    chk_resp("excl write 2", RESP_OKAY, got);
    chk_strb("failed strobes", 4'h0, seen_strb);
    rd(2'h3, 32'h0100_0400, 1'b0);
    chk_resp("plain read", RESP_OKAY, got);
    $display("test two_mon done");
  endtask : t_two_mon
  // other-master writes around the monitored word, edges of the mask
  task automatic t_mask();
    logic [31:0] a[4] = '{32'h104, 32'h110, 32'h0FC, 32'h0F8};
    logic [7:0]  n[4] = '{8'h01, 8'h00, 8'h01, 8'h01};
    for (int j = 0; j < 4; j++) begin
      rd(2'h0, 32'h100, 1'b1);
      wr(2'h1, a[j], n[j], 1'b0);
      chk_resp("other write", RESP_OKAY, got);
      wr(2'h0, 32'h100, 8'h00, 1'b1);
      chk_resp("excl write", j[0] ? RESP_EXOKAY : RESP_OKAY, got);
      chk_strb("excl strobes", j[0] ? 4'hF : 4'h0, seen_strb);
    end
    $display("test mask done");
  endtask : t_mask
  // manager beats a read; a read on the other interface waits for the first one's data
  task automatic t_order();
    logic fst;
    fst = 1'b0;
    @(negedge ref_clk);
    {mgr_valid, mgr_addr} = {1'b1, 32'h80};
    {ar_valid, ar_id, ar_addr, ar_len, ar_size, ar_lock} = {1'b1, 2'h1, 32'h40, 8'h00, 3'h2, 1'b0};
    k = 0;
    do @(posedge ref_clk); while (!mgr_ready && !ar_ready && ++k < 50);
    chk_word("manager first", 32'h2, 32'({mgr_ready, ar_ready}));
    @(negedge ref_clk);
    mgr_valid = 1'b0;
    k = 0;
    do @(posedge ref_clk); while (!ar_ready && ++k < 50);
    if (k == 50) n_mismatch++;
    @(negedge ref_clk);
    ar_addr = 32'h0100_0040;
    k = 0;
    do begin
      @(posedge ref_clk);
      fst = fst | (r_valid && !ar_ready);
    end while (!ar_ready && ++k < 50);
    chk_word("data before other interface", 32'h1, 32'(fst));
    @(negedge ref_clk);
    ar_valid = 1'b0;
    k = 0;
    do @(posedge ref_clk); while (!(r_valid && r_last) && ++k < 50);
    chk_word("second read data", 32'hA500_0000, r_data);
    chk_word("second read id", 32'h1, 32'(r_id));
    $display("test order done");
  endtask : t_order
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // watchdog: a few hundred cycles expected
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {ar_valid, aw_valid, w_valid, mgr_valid, ar_lock, aw_lock, w_last, w_strb} = '0;
    {ar_addr, aw_addr, mgr_addr, ar_id, aw_id, ar_len, aw_len, ar_size, aw_size} = '0;
    {b_ready, r_ready} = 2'b11;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    t_two_mon();
    t_mask();
    t_order();
    final_report();
  end
endmodule : axm_front_test
`default_nettype wire
